// >>> src/pipe_cfg_pkg.sv
// package: register map, field layout and timing constants of the host pipe block
package pipe_cfg_pkg;
  localparam int NUM_PIPES = 7;
  // byte addresses of the registers
  localparam logic [11:0] ADDR_BUS_CTRL = 12'h400;
  localparam logic [11:0] ADDR_PIPE_RST_EN = 12'h41C;
  localparam logic [11:0] ADDR_FRAME_NUM = 12'h420;
  localparam logic [11:0] ADDR_HOST_ADDR_LOW = 12'h424;
  localparam logic [11:0] ADDR_HOST_ADDR_HIGH = 12'h428;
  localparam logic [11:0] ADDR_PIPE_CFG = 12'h500;
  localparam logic [11:0] ADDR_PIPE_STATUS = 12'h530;
  localparam logic [11:0] ADDR_PIPE_CTRL = 12'h5C0;
  // field positions
  localparam int BUS_RESET_BIT = 0;
  localparam int EN_LSB = 0;
  localparam int RST_LSB = 16;
  localparam int FLEN_LSB = 16;
  localparam int SOF_FRAME_NUMBER_LSB = 3;
  localparam int CFG_MEMORY_ALLOCATE = 1;
  localparam int CFG_BANK_LSB = 2;
  localparam int CFG_SIZE_LSB = 4;
  localparam int CFG_TOKEN_LSB = 8;
  localparam int CFG_AUTO_BANK_SWITCH = 10;
  localparam int CFG_TYPE_LSB = 12;
  localparam int CFG_EP_LSB = 16;
  localparam int CFG_INT_LSB = 24;
  localparam int STA_CFGOK = 18;
  localparam int STA_RWALL = 16;
  localparam int STA_DTSEQ_LSB = 8;
  localparam logic [31:0] RESET_VALUE = 32'h00000000;
  // timing
  localparam int CLK_HZ = 20000000;
  localparam int FRAME_TICK_HZ = 12000000;
  localparam logic [13:0] FRAME_LEN = 14'h2EE0; // 12000 ticks
  localparam logic [7:0] POLL_TICK_LEN = 8'h0C; // 12 frame ticks per poll step unit
  typedef enum logic [1:0] {TYPE_CONTROL, TYPE_ISO, TYPE_BULK, TYPE_INTERRUPT} transfer_type_t;
  typedef enum logic [1:0] {TOKEN_SETUP, TOKEN_IN, TOKEN_OUT, TOKEN_RSVD} token_direction_t;
  typedef struct packed {
    logic [7:0] poll_interval_ms;
    logic [3:0] target_endpoint_number;
    transfer_type_t transfer_type;
    logic auto_bank_switch;
    token_direction_t token_direction;
    logic [2:0] bank_size_code;
    logic [1:0] bank_count_code;
    logic memory_allocate;
  } pipe_cfg_t;
  typedef struct packed {
    logic active;
    logic [10:0] bank_bytes;
    logic [1:0] banks;
    logic poll_due;
  } pipe_view_t;
endpackage : pipe_cfg_pkg

// >>> src/pipe_slot.sv
// module: one pipe's configuration decode, poll timer and state
`timescale 1ns/10ps
module pipe_slot (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic frame_start_i,
  input wire logic enable_i,
  input wire logic fifo_reset_i,
  input wire pipe_cfg_pkg::pipe_cfg_t cfg_i,
  // results
  output logic cfg_ok_o,
  output logic data_toggle_o,
  output logic toggle_i_dummy_o,
  output pipe_cfg_pkg::pipe_view_t view_o
);
  logic [7:0] poll_count;
  logic [7:0] next_poll_count;
  logic toggle;
  logic next_toggle;
  logic valid;
  // reserved codes make the setup invalid
  always_comb begin
    valid = (cfg_i.token_direction != pipe_cfg_pkg::TOKEN_RSVD) && (cfg_i.bank_count_code != 2'h3);
  end
  // poll timer counts frames for interrupt pipes only
  always_comb begin
    next_poll_count = poll_count;
    next_toggle = toggle;
    if (!enable_i) begin
      next_poll_count = 8'h00;
      next_toggle = 1'b0;
    end else if (fifo_reset_i) begin
      next_poll_count = 8'h00; // toggle kept
    end else if (frame_start_i && cfg_i.transfer_type == pipe_cfg_pkg::TYPE_INTERRUPT) begin
      if (poll_count + 8'h01 >= cfg_i.poll_interval_ms) next_poll_count = 8'h00;
      else next_poll_count = poll_count + 8'h01;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      poll_count <= 8'h00;
      toggle <= 1'b0;
    end else begin
      poll_count <= next_poll_count;
      toggle <= next_toggle;
    end
  end
  // decoded view of the pipe
  always_comb begin
    view_o.active = enable_i && !fifo_reset_i && valid && cfg_i.memory_allocate;
    view_o.bank_bytes = 11'h008 << cfg_i.bank_size_code;
    view_o.banks = cfg_i.bank_count_code + 2'h1;
    view_o.poll_due = (cfg_i.transfer_type != pipe_cfg_pkg::TYPE_INTERRUPT) || (poll_count == 8'h00);
    cfg_ok_o = valid && cfg_i.memory_allocate;
    data_toggle_o = toggle;
    toggle_i_dummy_o = cfg_i.auto_bank_switch;
  end
endmodule : pipe_slot

// >>> src/usb_host_pipe_config.sv
// module: host pipe registers, frame counter and wishbone slave
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/10ps
module usb_host_pipe_config #(
  parameter int NUM_PIPES = pipe_cfg_pkg::NUM_PIPES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // link side
  output logic sof_o,
  output logic bus_reset_o,
  output logic [NUM_PIPES-1:0] pipe_active_o,
  output logic [NUM_PIPES-1:0] poll_due_o,
  output logic [NUM_PIPES-1:0] auto_switch_o
);
  logic [13:0] frame_count;
  logic [13:0] next_frame_count;
  logic [10:0] frame_number;
  logic [10:0] next_frame_number;
  logic [15:0] tick_acc;
  logic [15:0] next_tick_acc;
  logic tick;
  logic bus_reset;
  logic next_bus_reset;
  logic [NUM_PIPES-1:0] enable;
  logic [NUM_PIPES-1:0] next_enable;
  logic [NUM_PIPES-1:0] fifo_reset;
  logic [NUM_PIPES-1:0] next_fifo_reset;
  logic [6:0] dev_addr [NUM_PIPES];
  logic [6:0] next_dev_addr [NUM_PIPES];
  pipe_cfg_pkg::pipe_cfg_t cfg [NUM_PIPES];
  pipe_cfg_pkg::pipe_cfg_t next_cfg [NUM_PIPES];
  logic [NUM_PIPES-1:0] cfg_ok;
  logic [NUM_PIPES-1:0] toggle;
  pipe_cfg_pkg::pipe_view_t view [NUM_PIPES];
  logic ack;
  logic [31:0] rdata;
  logic [31:0] wmask;
  logic wr;
  logic sof;
  logic next_ack;
  logic hit_bus_ctrl;
  logic hit_rst_en;
  logic hit_frame;
  logic hit_addr_low;
  logic hit_addr_high;
  logic [NUM_PIPES-1:0] hit_cfg;
  logic [NUM_PIPES-1:0] hit_status;
  logic [31:0] cfg_word [NUM_PIPES];
  logic [31:0] status_word [NUM_PIPES];
  logic [31:0] ctrl_word;
  logic [31:0] rst_en_word;
  logic [31:0] frame_word;
  logic [31:0] addr_low_word;
  logic [31:0] addr_high_word;

  // register image of a pipe configuration, every field at its bus bit position
  function automatic logic [31:0] cfg_to_word(input pipe_cfg_pkg::pipe_cfg_t c);
    logic [31:0] w;
    w = 32'h00000000;
    w[pipe_cfg_pkg::CFG_MEMORY_ALLOCATE] = c.memory_allocate;
    w[pipe_cfg_pkg::CFG_BANK_LSB +: 2] = c.bank_count_code;
    w[pipe_cfg_pkg::CFG_SIZE_LSB +: 3] = c.bank_size_code;
    w[pipe_cfg_pkg::CFG_TOKEN_LSB +: 2] = c.token_direction;
    w[pipe_cfg_pkg::CFG_AUTO_BANK_SWITCH] = c.auto_bank_switch;
    w[pipe_cfg_pkg::CFG_TYPE_LSB +: 2] = c.transfer_type;
    w[pipe_cfg_pkg::CFG_EP_LSB +: 4] = c.target_endpoint_number;
    w[pipe_cfg_pkg::CFG_INT_LSB +: 8] = c.poll_interval_ms;
    return w;
  endfunction : cfg_to_word

  // fields picked out of a bus word; reserved bit positions are dropped here
  function automatic pipe_cfg_pkg::pipe_cfg_t word_to_cfg(input logic [31:0] w);
    pipe_cfg_pkg::pipe_cfg_t c;
    c.memory_allocate = w[pipe_cfg_pkg::CFG_MEMORY_ALLOCATE];
    c.bank_count_code = w[pipe_cfg_pkg::CFG_BANK_LSB +: 2];
    c.bank_size_code = w[pipe_cfg_pkg::CFG_SIZE_LSB +: 3];
    c.token_direction = pipe_cfg_pkg::token_direction_t'(w[pipe_cfg_pkg::CFG_TOKEN_LSB +: 2]);
    c.auto_bank_switch = w[pipe_cfg_pkg::CFG_AUTO_BANK_SWITCH];
    c.transfer_type = pipe_cfg_pkg::transfer_type_t'(w[pipe_cfg_pkg::CFG_TYPE_LSB +: 2]);
    c.target_endpoint_number = w[pipe_cfg_pkg::CFG_EP_LSB +: 4];
    c.poll_interval_ms = w[pipe_cfg_pkg::CFG_INT_LSB +: 8];
    return c;
  endfunction : word_to_cfg

  // status image: configuration ok, access allowed and data toggle
  function automatic logic [31:0] status_to_word(input logic ok, input logic allowed, input logic dt);
    logic [31:0] w;
    w = 32'h00000000;
    w[pipe_cfg_pkg::STA_CFGOK] = ok;
    w[pipe_cfg_pkg::STA_RWALL] = allowed; // fifo state cleared by pipe reset
    w[pipe_cfg_pkg::STA_DTSEQ_LSB] = dt;
    return w;
  endfunction : status_to_word

  // address decode of the global registers, one hit line each
  always_comb begin
    hit_bus_ctrl = (adr_i == pipe_cfg_pkg::ADDR_BUS_CTRL);
    hit_rst_en = (adr_i == pipe_cfg_pkg::ADDR_PIPE_RST_EN);
    hit_frame = (adr_i == pipe_cfg_pkg::ADDR_FRAME_NUM);
    hit_addr_low = (adr_i == pipe_cfg_pkg::ADDR_HOST_ADDR_LOW);
    hit_addr_high = (adr_i == pipe_cfg_pkg::ADDR_HOST_ADDR_HIGH);
  end
  // byte lane mask and a write strobe taken on the acking edge
  always_comb begin
    wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    wr = cyc_i && stb_i && we_i && !ack;
  end
  // fractional 12 MHz tick from the 20 MHz clock
  always_comb begin
    next_tick_acc = tick_acc + 16'(pipe_cfg_pkg::FRAME_TICK_HZ / 1000);
    tick = 1'b0;
    if (next_tick_acc >= 16'(pipe_cfg_pkg::CLK_HZ / 1000)) begin
      next_tick_acc = next_tick_acc - 16'(pipe_cfg_pkg::CLK_HZ / 1000);
      tick = 1'b1;
    end
  end
  // frame counter and frame number
  always_comb begin
    next_frame_count = frame_count;
    next_frame_number = frame_number;
    sof = 1'b0;
    if (tick) begin
      if (frame_count == pipe_cfg_pkg::FRAME_LEN - 14'h0001) begin
        next_frame_count = 14'h0000;
        next_frame_number = frame_number + 11'h001;
        sof = 1'b1;
      end else begin
        next_frame_count = frame_count + 14'h0001;
      end
    end
    if (wr && hit_frame && sel_i[1] && sel_i[0]) begin
      next_frame_number = dat_i[pipe_cfg_pkg::SOF_FRAME_NUMBER_LSB +: 11];
    end
  end
  // bus answer: each request is acked once, in the cycle after it is seen
  always_comb begin
    next_ack = cyc_i && stb_i && !ack;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      dat_o <= pipe_cfg_pkg::RESET_VALUE;
    end else begin
      ack <= next_ack;
      dat_o <= rdata; // read data stands in the ack cycle
    end
  end
  // timebase state: tick accumulator, frame counter and frame number
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_acc <= 16'h0000;
      frame_count <= 14'h0000;
      frame_number <= 11'h000;
      sof_o <= 1'b0;
    end else begin
      tick_acc <= next_tick_acc;
      frame_count <= next_frame_count;
      frame_number <= next_frame_number;
      sof_o <= sof;
    end
  end
  // control bits: bus reset request, pipe enables and pipe resets
  always_comb begin
    next_bus_reset = bus_reset;
    next_enable = enable;
    next_fifo_reset = fifo_reset;
    if (wr && hit_bus_ctrl && sel_i[0]) begin
      next_bus_reset = dat_i[pipe_cfg_pkg::BUS_RESET_BIT];
    end
    if (wr && hit_rst_en) begin
      if (sel_i[0]) begin
        next_enable = dat_i[pipe_cfg_pkg::EN_LSB +: NUM_PIPES];
      end
      if (sel_i[2]) begin
        next_fifo_reset = dat_i[pipe_cfg_pkg::RST_LSB +: NUM_PIPES];
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_reset <= 1'b0;
      enable <= '0;
      fifo_reset <= '0;
    end else begin
      bus_reset <= next_bus_reset;
      enable <= next_enable;
      fifo_reset <= next_fifo_reset;
    end
  end
  // target device addresses, one byte lane per pipe, four in the low word
  always_comb begin
    for (int p = 0; p < NUM_PIPES; p++) begin
      next_dev_addr[p] = dev_addr[p];
      if (wr && (p < 4 ? hit_addr_low : hit_addr_high) && sel_i[p % 4]) begin
        next_dev_addr[p] = dat_i[(p % 4) * 8 +: 7];
      end
      // a requested bus reset wipes every address, writes included
      if (next_bus_reset) begin
        next_dev_addr[p] = 7'h00;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < NUM_PIPES; p++) begin
      if (rst_i) begin
        dev_addr[p] <= 7'h00;
      end else begin
        dev_addr[p] <= next_dev_addr[p];
      end
    end
  end
  // pipe configurations, merged lane by lane through their bus image
  always_comb begin
    for (int p = 0; p < NUM_PIPES; p++) begin
      next_cfg[p] = cfg[p];
      if (wr && hit_cfg[p]) begin
        next_cfg[p] = word_to_cfg((cfg_word[p] & ~wmask) | (dat_i & wmask));
      end
      // a disabled pipe keeps only allocation, banks and size, so enable before configuring
      if (!next_enable[p]) begin
        next_cfg[p] = '0;
        next_cfg[p].memory_allocate = cfg[p].memory_allocate;
        next_cfg[p].bank_count_code = cfg[p].bank_count_code;
        next_cfg[p].bank_size_code = cfg[p].bank_size_code;
      end
      // bus reset clears every field, allocation included
      if (next_bus_reset) begin
        next_cfg[p] = '0;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < NUM_PIPES; p++) begin
      if (rst_i) begin
        cfg[p] <= '0;
      end else begin
        cfg[p] <= next_cfg[p];
      end
    end
  end
  // read images of the global registers
  always_comb begin
    ctrl_word = 32'h00000000;
    ctrl_word[pipe_cfg_pkg::BUS_RESET_BIT] = bus_reset;
    rst_en_word = 32'h00000000;
    rst_en_word[pipe_cfg_pkg::EN_LSB +: NUM_PIPES] = enable;
    rst_en_word[pipe_cfg_pkg::RST_LSB +: NUM_PIPES] = fifo_reset;
    frame_word = 32'h00000000;
    frame_word[pipe_cfg_pkg::FLEN_LSB +: 8] = frame_count[13:6];
    frame_word[pipe_cfg_pkg::SOF_FRAME_NUMBER_LSB +: 11] = frame_number;
  end
  // read images of the two address registers, bit 7 of each lane reads zero
  always_comb begin
    addr_low_word = 32'h00000000;
    addr_high_word = 32'h00000000;
    for (int p = 0; p < NUM_PIPES; p++) begin
      if (p < 4) begin
        addr_low_word[(p % 4) * 8 +: 7] = dev_addr[p];
      end else begin
        addr_high_word[(p % 4) * 8 +: 7] = dev_addr[p];
      end
    end
  end
  // read mux; hits are exclusive and unmapped reads give zero
  always_comb begin
    rdata = 32'h00000000;
    if (hit_bus_ctrl) begin
      rdata = ctrl_word;
    end
    if (hit_rst_en) begin
      rdata = rst_en_word;
    end
    if (hit_frame) begin
      rdata = frame_word;
    end
    if (hit_addr_low) begin
      rdata = addr_low_word;
    end
    if (hit_addr_high) begin
      rdata = addr_high_word;
    end
    for (int p = 0; p < NUM_PIPES; p++) begin
      if (hit_cfg[p]) begin
        rdata = cfg_word[p];
      end
      if (hit_status[p]) begin
        rdata = status_word[p];
      end
    end
  end
  // one slot per pipe
  for (genvar g = 0; g < NUM_PIPES; g++) begin : g_pipe
    pipe_slot u_slot (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .frame_start_i(sof),
      .enable_i(enable[g]),
      .fifo_reset_i(fifo_reset[g]),
      .cfg_i(cfg[g]),
      .cfg_ok_o(cfg_ok[g]),
      .data_toggle_o(toggle[g]),
      .toggle_i_dummy_o(auto_switch_o[g]),
      .view_o(view[g])
    );
    assign pipe_active_o[g] = view[g].active && !bus_reset;
    assign poll_due_o[g] = view[g].poll_due;
    // per-pipe address hits and read images
    assign hit_cfg[g] = (adr_i == pipe_cfg_pkg::ADDR_PIPE_CFG + 12'(g * 4));
    assign hit_status[g] = (adr_i == pipe_cfg_pkg::ADDR_PIPE_STATUS + 12'(g * 4));
    assign cfg_word[g] = cfg_to_word(cfg[g]);
    assign status_word[g] = status_to_word(cfg_ok[g], view[g].active, toggle[g]);
  end
  assign ack_o = ack;
  assign bus_reset_o = bus_reset;
endmodule : usb_host_pipe_config

// >>> tb/usb_device_model.sv
// partner: attached device, counts the frames that reach it and flags any bus reset
`timescale 1ns/10ps
module usb_device_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link side from the host block
  input wire logic sof_i,
  input wire logic bus_reset_i,
  // observations
  output logic [7:0] frames_o,
  output logic resets_seen_o
);
  // a device held in bus reset restarts its frame count
  always_ff @(posedge clk_i) begin
    if (rst_i || bus_reset_i) begin
      frames_o <= 8'h00;
    end else if (sof_i) begin
      frames_o <= frames_o + 8'h01;
    end
  end
  // remember any bus reset seen since power up
  always_ff @(posedge clk_i) begin
    resets_seen_o <= !rst_i && (resets_seen_o || bus_reset_i);
  end
endmodule : usb_device_model

// >>> tb/usb_host_pipe_config_assertions.sv
// checker: bus answer, frame timing and pipe output relations
`timescale 1ns/10ps
module usb_host_pipe_config_assertions #(
  parameter int NUM_PIPES = 7
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone side
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // link side
  input wire logic sof_o,
  input wire logic bus_reset_o,
  input wire logic [NUM_PIPES-1:0] pipe_active_o,
  input wire logic [NUM_PIPES-1:0] poll_due_o,
  input wire logic [NUM_PIPES-1:0] auto_switch_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [14:0] gap;
  logic seen;
  // cycles since the last frame pulse, forgotten across a bus reset
  always_ff @(posedge clk_i) begin
    if (rst_i || bus_reset_o) begin
      gap <= 15'h0000;
      seen <= 1'b0;
    end else if (sof_o) begin
      gap <= 15'h0000;
      seen <= 1'b1;
    end else begin
      gap <= gap + 15'h0001;
    end
  end
  // a request is taken, answered next cycle, answer lasts one cycle
  sequence s_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_answer;
    ack_o ##1 !ack_o;
  endsequence
  property p_ack_latency;
    s_take |=> s_answer;
  endproperty
  a_ack_latency: assert property (p_ack_latency) else $error("late or long ack");
  property p_ack_cause;
    ack_o |-> $past(cyc_i && stb_i && !ack_o);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_unmapped_read;
    cyc_i && stb_i && !ack_o && !we_i && adr_i == 12'h7F0 |=> dat_o == 32'h00000000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");
  property p_sof_pulse;
    sof_o |=> !sof_o;
  endproperty
  a_sof_pulse: assert property (p_sof_pulse) else $error("frame pulse too long");
  property p_frame_period;
    sof_o && seen |-> gap == 15'h4E1F;
  endproperty
  a_frame_period: assert property (p_frame_period) else $error("frame period wrong");
  property p_frame_late;
    seen |-> gap < 15'h4E20;
  endproperty
  a_frame_late: assert property (p_frame_late) else $error("frame pulse missing");
  property p_bus_reset_idle;
    (bus_reset_o || $fell(bus_reset_o)) |-> pipe_active_o == '0;
  endproperty
  a_bus_reset_idle: assert property (p_bus_reset_idle) else $error("pipe active in bus reset");
  property p_bus_reset_cfg;
    bus_reset_o |=> auto_switch_o == '0 && poll_due_o == '1;
  endproperty
  a_bus_reset_cfg: assert property (p_bus_reset_cfg) else $error("config kept in bus reset");
  property p_active_cause;
    $changed(pipe_active_o) |-> (ack_o && we_i) || $past(ack_o && we_i);
  endproperty
  a_active_cause: assert property (p_active_cause) else $error("pipe state moved unasked");
endmodule : usb_host_pipe_config_assertions

bind usb_host_pipe_config usb_host_pipe_config_assertions #(.NUM_PIPES(NUM_PIPES)) i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .dat_o(dat_o), .ack_o(ack_o), .sof_o(sof_o), .bus_reset_o(bus_reset_o), .pipe_active_o(pipe_active_o),
  .poll_due_o(poll_due_o), .auto_switch_o(auto_switch_o));

// >>> tb/usb_host_pipe_config_test.sv
// testbench: registers, pipe control, frame timing and bus reset of the host pipe block
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; $display("mismatch %0t %h %h", $time, a, b); end end
module usb_host_pipe_config_test;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, sof_o, bus_reset_o, resets_seen;
  logic [11:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [6:0] pipe_active_o, poll_due_o, auto_switch_o;
  logic [7:0] frames;
  logic [31:0] cfg [7];
  logic [11:0] regs [6] = '{12'h41C, 12'h424, 12'h428, 12'h500, 12'h530, 12'h7F0};
  int errors, checks_done, n, f;
  usb_host_pipe_config i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sof_o(sof_o),
    .bus_reset_o(bus_reset_o), .pipe_active_o(pipe_active_o), .poll_due_o(poll_due_o),
    .auto_switch_o(auto_switch_o));
  usb_device_model i_dev (.clk_i(clk_i), .rst_i(rst_i), .sof_i(sof_o), .bus_reset_i(bus_reset_o),
    .frames_o(frames), .resets_seen_o(resets_seen));
  // 20 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // one classic bus cycle; read data lands in rd
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack_o !== 1'b1 && t < 50);
    rd = dat_o;
    {cyc_i, stb_i} <= 2'b00;
    if (t >= 50) errors++;
  endtask : wb
  // wait for one frame pulse, bounded
  task automatic wait_sof;
    int t;
    t = 0;
    while (sof_o !== 1'b1 && t < 25000) begin
      @(posedge clk_i);
      t++;
    end
    if (t >= 25000) errors++;
    @(posedge clk_i);
  endtask : wait_sof
  // pipe may carry traffic
  function automatic logic exp_act(input logic [31:0] c);
    return c[1] && c[9:8] != 2'b11 && c[3:2] != 2'b11;
  endfunction : exp_act
  task automatic print_verdict;
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // watchdog
  initial begin
    #(50 * 80000);
    errors++;
    print_verdict();
  end
  // main sequence
  initial begin
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i, rst_i} = {47'h0, 4'hF, 1'b1};
    errors = 0;
    checks_done = 0;
    n = $urandom(32'hC2B4EDE7);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, 12'h7F0, $urandom);
    foreach (regs[i]) begin
      wb(1'b0, regs[i], 32'h0);
      `CHK(rd, 32'h00000000)
    end
    `CHK(poll_due_o, 7'h7F)
    for (n = 0; n < 2; n++) begin
      cfg[n] = $urandom & (n == 1 ? 32'h007F7F7F : 32'h7F7F7F7F);
      wb(1'b1, 12'(12'h424 + 4 * n), cfg[n]);
      wb(1'b0, 12'(12'h424 + 4 * n), 32'h0);
      `CHK(rd, cfg[n])
    end
    // pipes are enabled first: a disabled pipe keeps only allocation, banks and size
    wb(1'b1, 12'h41C, 32'h0000007F);
    for (n = 0; n < 7; n++) begin
      cfg[n] = $urandom & 32'hFF0F047E | 32'h00000002;
      cfg[n][13:12] = n[1:0];
      cfg[n][9:8] = (n == 6) ? 2'b11 : 2'(n % 3);
      if (n == 0 || cfg[n][3:2] == 2'b11) cfg[n][3:2] = 2'b00;
      if (n == 5) cfg[n][3:2] = 2'b11;
      wb(1'b1, 12'(12'h500 + 4 * n), cfg[n]);
    end
    @(negedge clk_i);
    for (n = 0; n < 7; n++) begin
      wb(1'b0, 12'(12'h500 + 4 * n), 32'h0);
      `CHK(rd, cfg[n])
      `CHK(auto_switch_o[n], cfg[n][10])
      `CHK(pipe_active_o[n], exp_act(cfg[n]))
      if (n != 3) `CHK(poll_due_o[n], 1'b1)
    end
    wb(1'b1, 12'h41C, 32'h0002007F);
    @(negedge clk_i);
    `CHK(pipe_active_o[1], 1'b0)
    wb(1'b0, 12'h41C, 32'h0);
    `CHK(rd, 32'h0002007F)
    wb(1'b0, 12'h504, 32'h0);
    `CHK(rd, cfg[1])
    wb(1'b1, 12'h41C, 32'h0000007B);
    @(negedge clk_i);
    `CHK(pipe_active_o[1], exp_act(cfg[1]))
    `CHK(pipe_active_o[2], 1'b0)
    wb(1'b0, 12'h508, 32'h0);
    `CHK(rd, cfg[2] & 32'h0000007E)
    f = $urandom_range(2000, 1);
    wb(1'b1, 12'h420, 32'(f) << 3);
    wb(1'b0, 12'h420, 32'h0);
    `CHK(rd[13:3], 11'(f))
    `CHK(rd[23:16] <= 8'hBB, 1'b1)
    wait_sof();
    wb(1'b0, 12'h420, 32'h0);
    `CHK(rd[13:3], 11'(f + 1))
    `CHK(rd[23:16], 8'h00)
    wait_sof();
    `CHK(frames, 8'h02)
    wb(1'b1, 12'h400, 32'h00000001);
    @(negedge clk_i);
    `CHK(resets_seen, 1'b1)
    for (n = 0; n < 9; n++) begin
      wb(1'b0, 12'(n < 2 ? 12'h424 + 4 * n : 12'h4F8 + 4 * n), 32'h0);
      `CHK(rd & (n < 2 ? 32'hFFFFFFFF : 32'hFF0F347E), 32'h0)
    end
    wb(1'b1, 12'h400, 32'h0);
    print_verdict();
  end
endmodule : usb_host_pipe_config_test
